//--- verilog/vrc_pkg.sv
// Package for the voice recorder channel control block.
// Assumes a single 250 MHz clock and an APB master for software access.
package vrc_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_CMD    = 12'h008;
    localparam logic [11:0] OFS_ADDR   = 12'h00C;
    localparam logic [11:0] OFS_VOICE  = 12'h010;
    // Control register fields
    localparam int CTRL_CHAN_LO  = 0;
    localparam int CTRL_WCNT_LO  = 3;
    localparam int CTRL_FLEX     = 5;
    localparam int CTRL_RATE     = 6;
    localparam int CTRL_VTRIG    = 7;
    localparam int CTRL_SLEEP    = 8;
    localparam int CTRL_DIR      = 9;
    localparam int CTRL_MCU      = 10;
    localparam int CTRL_MEMSEL   = 11;
    // Status nibble bit positions, top bit first
    localparam int ST_FULL   = 3;
    localparam int ST_WAIT   = 2;
    localparam int ST_ACTIVE = 1;
    localparam int ST_BUSY   = 0;
    // Sample rate dividers
    localparam logic [9:0] DIV_SLOW = 10'd768;
    localparam logic [9:0] DIV_FAST = 10'd512;
    // Memory geometry: addresses in 1Kbit words
    localparam logic [11:0] VOICE_BASE = 12'h008;
    localparam logic [11:0] MEM_MAX_256K = 12'h0FF;
    localparam logic [11:0] SAMPLES_PER_WORD = 12'd256;
    // Busy times
    localparam int BUSY_CMD_US  = 16;
    localparam int CLK_MHZ      = 250;
    localparam int BUSY_CMD_CYC = BUSY_CMD_US * CLK_MHZ;
    localparam int BUSY_RST_US  = 125;
    localparam int BUSY_RST_CYC = BUSY_RST_US * CLK_MHZ;
    // Command nibbles
    localparam logic [3:0] CMD_PAUSE = 4'h1;
    localparam logic [3:0] CMD_PLAY  = 4'h2;
    localparam logic [3:0] CMD_REC   = 4'h3;
    localparam logic [3:0] CMD_START = 4'h4;
    localparam logic [3:0] CMD_STOP  = 4'h5;
    localparam logic [3:0] CMD_SAMP  = 4'h6;
    localparam logic [3:0] CMD_CHAN  = 4'h7;

    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_VWAIT  = 5'b00010,
        S_RUN    = 5'b00100,
        S_PAUSE  = 5'b01000,
        S_SLEEP  = 5'b10000
    } vrc_state_t;

    typedef struct packed {
        logic       begin_p;
        logic       halt_p;
        logic       pause_p;
    } vrc_evt_t;
endpackage

//--- verilog/vrc_top.sv
// Channel control for an eight-channel ADPCM recorder.
// Assumes an APB master on CLK; stand-alone pins are asynchronous.
// Summary of operation
// - Direct and flex modes decode three select bits to eight channels.
// - Fixed mode decodes channels by word count: 8, 4 or 2.
// - Fixed mode region is memory above the voice base divided by word count.
// - Sleep policy low, stand-alone mode only: power down whenever idle.
// - Sleep policy high: power down only while reset held low.
// - Powered down: sample divider held at zero; control and addresses keep their values.
// - Sample rate is master clock divided by 768 or 512.
// - Direction high then begin pulse records until halt pulse.
// - Recording ends by itself at end of channel region.
// - Activity indicator high while recording or playing, not while paused or waiting for voice.
// - Direction low then begin plays; stops at length or halt.
// - Begin held low in playback repeats the message.
// - Pause suspends; begin resumes; halt ends.
// - Resuming a paused recording skips the voice trigger.
// - Voice trigger enabled: begin waits for voice, then records.
// - Halt during voice wait returns to idle.
// - Fixed re-record starts at the channel's own region start.
// - Flex channel n starts after stop of n-1, runs to memory end.
// - Chip-enable high ignores strobes and floats data pins.
// - Write strobe latches a nibble; read strobe drives status.
// - Status nibble: full, wait/pause, active, busy.
// - Busy high during reset sequence and command processing.
module vrc_top #(
    parameter int BUSY_CMD_CYC = vrc_pkg::BUSY_CMD_CYC,
    parameter int BUSY_RST_CYC = vrc_pkg::BUSY_RST_CYC
) (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        BEGIN_PULSE_PIN_N,
    input  wire logic        HALT_PULSE_PIN_N,
    input  wire logic        PAUSE_PIN_N,
    input  wire logic        VOICE_DETECT,
    input  wire logic        CE_N,
    input  wire logic        WR_N,
    input  wire logic        RD_N,
    input  wire logic [3:0]  DATA_IN,
    output logic      [3:0]  DATA_OUT,
    output logic             DATA_OE_N,
    output logic             ACTIVITY_INDICATOR,
    output logic             POWER_DOWN,
    output logic             SAMPLE_TICK,
    output logic      [11:0] MEM_ADDR
);
    // Channel decode shared by the region and start address logic
    function automatic logic [2:0] chan_of(input logic [2:0] sel, input logic [1:0] wc, input logic flex);
        if (flex || wc == 2'b00)
            chan_of = sel;
        else if (wc == 2'b10)
            chan_of = {2'b00, sel[2]};
        else
            chan_of = {1'b0, sel[2:1]};
    endfunction

    logic [12:0] ctrl;
    logic [2:0]  s1, s2, s3, s3d;
    vrc_pkg::vrc_evt_t ev;
    vrc_pkg::vrc_state_t state;
    logic        rec_mode;
    logic        full;
    logic        busy;
    logic [31:0] busy_cnt;
    logic [9:0]  div_cnt;
    logic [11:0] addr;
    logic [11:0] stop_addr;
    logic [11:0] ch_stop [8];
    logic [2:0]  ch;
    logic [11:0] region_lo;
    logic [11:0] region_hi;
    logic [11:0] mem_max;
    logic [2:0]  ce_s, wr_s, rd_s, vd_s;
    logic        wr_hi;
    logic [3:0]  nib;
    logic        second;
    logic [3:0]  pend;

    // Begin, halt, pause: three stages, act when stages two and three agree
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s1  <= 3'h7;
            s2  <= 3'h7;
            s3  <= 3'h7;
            s3d <= 3'h7;
        end
        else
        begin
            s1  <= {BEGIN_PULSE_PIN_N, HALT_PULSE_PIN_N, PAUSE_PIN_N};
            s2  <= s1;
            s3  <= s2;
            s3d <= s2 == s3 ? s3 : s3d;
        end
    end
    assign ev = vrc_pkg::vrc_evt_t'(~s3 & s3d & ~(s2 ^ s3));

    // Nibble bus strobes
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ce_s <= 3'h7;
            wr_s <= 3'h7;
            rd_s <= 3'h7;
            vd_s <= 3'h0;
            wr_hi <= 1'b1;
        end
        else
        begin
            ce_s <= {ce_s[1:0], CE_N};
            wr_s <= {wr_s[1:0], WR_N};
            rd_s <= {rd_s[1:0], RD_N};
            vd_s <= {vd_s[1:0], VOICE_DETECT};
            wr_hi <= wr_s[2] == wr_s[1] ? wr_s[2] : wr_hi;
        end
    end
    logic wr_fall;
    logic cmd_begin;
    logic cmd_halt;
    logic cmd_pause;
    logic mcu;
    assign mcu     = ctrl[vrc_pkg::CTRL_MCU];
    assign wr_fall = mcu && !ce_s[2] && !ce_s[1] && wr_hi && !wr_s[2] && !wr_s[1];
    assign cmd_begin = wr_fall && !second && nib == vrc_pkg::CMD_START;
    assign cmd_halt  = wr_fall && !second && nib == vrc_pkg::CMD_STOP;
    assign cmd_pause = wr_fall && !second && nib == vrc_pkg::CMD_PAUSE;
    assign nib = DATA_IN;

    logic do_begin;
    logic do_halt;
    logic do_pause;
    logic begin_held;
    assign do_begin   = mcu ? cmd_begin : ev.begin_p;
    assign do_halt    = mcu ? cmd_halt  : ev.halt_p;
    assign do_pause   = mcu ? cmd_pause : ev.pause_p;
    assign begin_held = !mcu && !s3[2] && !s2[2];

    // Nibble command latch and busy timer
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            second   <= 1'b0;
            pend     <= 4'h0;
            busy     <= 1'b1;
            busy_cnt <= 32'(BUSY_RST_CYC);
        end
        else
        begin
            if (wr_fall)
            begin
                busy     <= 1'b1;
                busy_cnt <= 32'(BUSY_CMD_CYC);
                second   <= !second && (nib == vrc_pkg::CMD_SAMP || nib == vrc_pkg::CMD_CHAN);
                pend     <= nib;
            end
            else if (busy_cnt != 32'h0)
                busy_cnt <= busy_cnt - 32'h1;
            else
                busy <= 1'b0;
        end
    end

    // Control register, also loaded by two-nibble commands
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ctrl <= 13'h0;
        else if (PSEL && PENABLE && PWRITE && PADDR == vrc_pkg::OFS_CTRL)
            ctrl <= PWDATA[12:0];
        else if (wr_fall && second && pend == vrc_pkg::CMD_SAMP)
        begin
            ctrl[vrc_pkg::CTRL_WCNT_LO +: 2] <= nib[3:2];
            ctrl[vrc_pkg::CTRL_RATE]         <= nib[1];
        end
        else if (wr_fall && second && pend == vrc_pkg::CMD_CHAN)
            ctrl[vrc_pkg::CTRL_CHAN_LO +: 3] <= nib[2:0];
        else if (wr_fall && !second && nib == vrc_pkg::CMD_REC)
            ctrl[vrc_pkg::CTRL_DIR] <= 1'b1;
        else if (wr_fall && !second && nib == vrc_pkg::CMD_PLAY)
            ctrl[vrc_pkg::CTRL_DIR] <= 1'b0;
    end

    // Geometry: memory end, channel region bounds
    logic [1:0]  wc;
    logic        flex;
    logic [11:0] span;
    assign wc      = ctrl[vrc_pkg::CTRL_WCNT_LO +: 2];
    assign flex    = ctrl[vrc_pkg::CTRL_FLEX] || wc == 2'b11;
    assign mem_max = ctrl[vrc_pkg::CTRL_MEMSEL +: 2] == 2'b00 ? vrc_pkg::MEM_MAX_256K
                   : 12'((vrc_pkg::MEM_MAX_256K + 12'h1) * (12'h1 << ctrl[vrc_pkg::CTRL_MEMSEL +: 2]) - 12'h1);
    assign ch      = chan_of(ctrl[vrc_pkg::CTRL_CHAN_LO +: 3], wc, flex);
    assign span    = wc == 2'b10 ? 12'((mem_max + 12'h1 - vrc_pkg::VOICE_BASE) >> 1)
                   : wc == 2'b01 ? 12'((mem_max + 12'h1 - vrc_pkg::VOICE_BASE) >> 2)
                   : 12'((mem_max + 12'h1 - vrc_pkg::VOICE_BASE) >> 3);
    always_comb
    begin
        if (flex)
        begin
            region_lo = ch == 3'h0 ? vrc_pkg::VOICE_BASE : 12'(ch_stop[ch - 3'h1] + 12'h1);
            region_hi = mem_max;
        end
        else
        begin
            region_lo = 12'(vrc_pkg::VOICE_BASE + span * 12'(ch));
            region_hi = 12'(region_lo + span - 12'h1);
        end
    end

    // Sample rate divider, stopped while asleep
    logic tick;
    assign tick = div_cnt == 10'h0;
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            div_cnt <= 10'h0;
        else if (state == vrc_pkg::S_SLEEP)
            div_cnt <= 10'h0;
        else if (tick)
            div_cnt <= ctrl[vrc_pkg::CTRL_RATE] ? vrc_pkg::DIV_FAST - 10'h1 : vrc_pkg::DIV_SLOW - 10'h1;
        else
            div_cnt <= div_cnt - 10'h1;
    end

    // Sequencer: one address step per sample tick
    logic end_reached;
    logic sleep_now;
    assign end_reached = tick && (rec_mode ? addr >= region_hi : addr >= stop_addr);
    assign sleep_now   = !mcu && !ctrl[vrc_pkg::CTRL_SLEEP];
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state     <= vrc_pkg::S_SLEEP;
            rec_mode  <= 1'b0;
            full      <= 1'b0;
            addr      <= vrc_pkg::VOICE_BASE;
            stop_addr <= vrc_pkg::VOICE_BASE;
            for (int i = 0; i < 8; i++)
                ch_stop[i] <= vrc_pkg::VOICE_BASE;
        end
        else
        begin
            case (state)
                vrc_pkg::S_SLEEP, vrc_pkg::S_IDLE:
                begin
                    if (do_begin || (begin_held && !ctrl[vrc_pkg::CTRL_DIR]))
                    begin
                        full      <= 1'b0;
                        rec_mode  <= ctrl[vrc_pkg::CTRL_DIR];
                        addr      <= region_lo;
                        stop_addr <= ch_stop[ch];
                        if (ctrl[vrc_pkg::CTRL_DIR] && ctrl[vrc_pkg::CTRL_VTRIG])
                            state <= vrc_pkg::S_VWAIT;
                        else
                            state <= vrc_pkg::S_RUN;
                    end
                    else if (sleep_now)
                        state <= vrc_pkg::S_SLEEP;
                    else
                        state <= vrc_pkg::S_IDLE;
                end
                vrc_pkg::S_VWAIT:
                begin
                    if (do_halt)
                        state <= vrc_pkg::S_IDLE;
                    else if (vd_s[2] && vd_s[1])
                        state <= vrc_pkg::S_RUN;
                end
                vrc_pkg::S_RUN:
                begin
                    if (do_halt || end_reached)
                    begin
                        if (rec_mode)
                        begin
                            ch_stop[ch] <= addr;
                            full        <= end_reached;
                        end
                        if (!rec_mode && !do_halt && begin_held)
                            addr <= region_lo;
                        else
                            state <= vrc_pkg::S_IDLE;
                    end
                    else if (do_pause)
                        state <= vrc_pkg::S_PAUSE;
                    else if (tick)
                        addr <= addr + 12'h1;
                end
                vrc_pkg::S_PAUSE:
                begin
                    if (do_halt)
                    begin
                        if (rec_mode)
                            ch_stop[ch] <= addr;
                        state <= vrc_pkg::S_IDLE;
                    end
                    else if (do_begin)
                        state <= vrc_pkg::S_RUN;
                end
                default:
                    state <= vrc_pkg::S_SLEEP;
            endcase
        end
    end

    // Nibble read path and outputs, all from flip-flops
    logic [3:0] status;
    assign status = {full, state == vrc_pkg::S_VWAIT || state == vrc_pkg::S_PAUSE,
                     state == vrc_pkg::S_RUN || state == vrc_pkg::S_PAUSE, busy};
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            DATA_OUT           <= 4'h0;
            DATA_OE_N          <= 1'b1;
            ACTIVITY_INDICATOR <= 1'b0;
            POWER_DOWN         <= 1'b1;
            SAMPLE_TICK        <= 1'b0;
            MEM_ADDR           <= 12'h0;
        end
        else
        begin
            DATA_OUT           <= status;
            DATA_OE_N          <= !(mcu && !ce_s[2] && !rd_s[2]);
            ACTIVITY_INDICATOR <= state == vrc_pkg::S_RUN;
            POWER_DOWN         <= state == vrc_pkg::S_SLEEP;
            SAMPLE_TICK        <= tick && state == vrc_pkg::S_RUN;
            MEM_ADDR           <= addr;
        end
    end

    // APB slave: zero wait states, unmapped reads zero with error
    logic mapped;
    assign mapped = PADDR == vrc_pkg::OFS_CTRL || PADDR == vrc_pkg::OFS_STATUS ||
                    PADDR == vrc_pkg::OFS_ADDR || PADDR == vrc_pkg::OFS_CMD || PADDR == vrc_pkg::OFS_VOICE;
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            PRDATA  <= 32'h0;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped;
            case (PADDR)
                vrc_pkg::OFS_CTRL:   PRDATA <= {19'h0, ctrl};
                vrc_pkg::OFS_STATUS: PRDATA <= {23'h0, state, status};
                vrc_pkg::OFS_ADDR:   PRDATA <= {4'h0, region_lo, 4'h0, addr};
                vrc_pkg::OFS_VOICE:  PRDATA <= {20'h0, stop_addr};
                default:             PRDATA <= 32'h0;
            endcase
        end
    end
endmodule

//--- sim/vrc_top_props.sv
// Concurrent checks on the ports of the recorder channel control block.
// Assumes one clock domain; bound to every vrc_top instance below.
module vrc_top_props #(
    parameter int BUSY_CMD_CYC = 8,
    parameter int BUSY_RST_CYC = 8
) (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CE_N,
    input wire logic        RD_N,
    input wire logic        DATA_OE_N,
    input wire logic        ACTIVITY_INDICATOR,
    input wire logic        POWER_DOWN,
    input wire logic        SAMPLE_TICK,
    input wire logic [11:0] MEM_ADDR
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] gap;
    logic       seen;
    logic       mapped;
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= vrc_pkg::OFS_VOICE);
    // Saturates so a long pause cannot wrap into a false short gap
    always_ff @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            gap <= 10'h000;
        else if (SAMPLE_TICK)
            gap <= 10'h000;
        else if (gap != 10'h3FF)
            gap <= gap + 10'h001;
    always_ff @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            seen <= 1'b0;
        else if (!ACTIVITY_INDICATOR)
            seen <= 1'b0;
        else if (SAMPLE_TICK)
            seen <= 1'b1;
    chk_apb_answer: assert property (PSEL && PENABLE && !$past(PENABLE) |-> PREADY)
        else $error("no answer in first access cycle");
    chk_ready_single: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
        else $error("ready outside access or held");
    chk_err_mapped: assert property (PREADY && mapped |-> !PSLVERR)
        else $error("error on mapped address");
    chk_err_unmapped: assert property (PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped address not refused");
    chk_run_awake: assert property (ACTIVITY_INDICATOR |-> !POWER_DOWN)
        else $error("asleep while running");
    chk_tick_idle: assert property (!ACTIVITY_INDICATOR && !$past(ACTIVITY_INDICATOR) |-> !SAMPLE_TICK)
        else $error("sample tick while idle");
    chk_tick_spacing: assert property (SAMPLE_TICK && seen |-> gap >= 10'd511)
        else $error("sample ticks closer than 512 clocks");
    chk_data_float: assert property ((CE_N || RD_N) [*6] |-> DATA_OE_N)
        else $error("data pins driven without read");
    chk_addr_base: assert property (ACTIVITY_INDICATOR |-> MEM_ADDR >= vrc_pkg::VOICE_BASE)
        else $error("address below voice area");
    cov_run: cover property ($rose(ACTIVITY_INDICATOR));
    cov_refuse: cover property (PREADY && PSLVERR);
    cov_read: cover property (!DATA_OE_N);
endmodule

bind vrc_top vrc_top_props #(.BUSY_CMD_CYC(BUSY_CMD_CYC), .BUSY_RST_CYC(BUSY_RST_CYC)) u_props (
    .CLK                (CLK),
    .ARST_N             (ARST_N),
    .PSEL               (PSEL),
    .PENABLE            (PENABLE),
    .PADDR              (PADDR),
    .PRDATA             (PRDATA),
    .PREADY             (PREADY),
    .PSLVERR            (PSLVERR),
    .CE_N               (CE_N),
    .RD_N               (RD_N),
    .DATA_OE_N          (DATA_OE_N),
    .ACTIVITY_INDICATOR (ACTIVITY_INDICATOR),
    .POWER_DOWN         (POWER_DOWN),
    .SAMPLE_TICK        (SAMPLE_TICK),
    .MEM_ADDR           (MEM_ADDR)
);

//--- sim/vrc_host_model.sv
// Host controller model on the nibble command bus.
// Assumes the bench calls send and rd_stat one at a time.
module vrc_host_model (
    input  wire logic       clk,
    input  wire logic [3:0] data_out,
    input  wire logic       data_oe_n,
    output logic            ce_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic [3:0]      data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        ce_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        data_in = 4'hA;
    end
    task automatic rd_stat(output logic [3:0] s);
        @(posedge clk);
        ce_n <= 1'b0;
        rd_n <= 1'b0;
        @(posedge clk);
        while (data_oe_n !== 1'b0)
            @(posedge clk);
        s = data_out;
        rd_n <= 1'b1;
        ce_n <= 1'b1;
        // Strobes are synchronised, so they need a few high cycles
        repeat (3) @(posedge clk);
    endtask
    task automatic send(input logic [3:0] nib);
        logic [3:0] s;
        s = 4'hF;
        while (s[vrc_pkg::ST_BUSY] !== 1'b0)
            rd_stat(s);
        @(posedge clk);
        ce_n <= 1'b0;
        data_in <= nib;
        wr_n <= 1'b0;
        repeat (4) @(posedge clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge clk);
        ce_n <= 1'b1;
        // Released pins carry no pull, so show a changed value
        data_in <= ~nib;
    endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the recorder channel control block.
// Assumes the host model drives the nibble bus; the bench owns APB and pins.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] SPAN = vrc_pkg::MEM_MAX_256K + 12'h001 - vrc_pkg::VOICE_BASE;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pn;
    logic        vd;
    logic        ce_n;
    logic        wr_n;
    logic        rd_n;
    logic [3:0]  din;
    logic [3:0]  dout;
    logic        oe_n;
    logic        act;
    logic        act_d;
    logic        pd;
    logic [11:0] maddr;
    logic [31:0] rv;
    logic        er;
    logic [3:0]  hs;
    logic [11:0] exp_q[$];
    int          n_errors;
    int          checks_done;
    int          cyc;
    int          ch;
    vrc_top #(.BUSY_CMD_CYC(8), .BUSY_RST_CYC(8)) uut (
        .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BEGIN_PULSE_PIN_N(pn[0]), .HALT_PULSE_PIN_N(pn[1]), .PAUSE_PIN_N(pn[2]),
        .VOICE_DETECT(vd), .CE_N(ce_n), .WR_N(wr_n), .RD_N(rd_n), .DATA_IN(din),
        .DATA_OUT(dout), .DATA_OE_N(oe_n), .ACTIVITY_INDICATOR(act), .POWER_DOWN(pd),
        .SAMPLE_TICK(), .MEM_ADDR(maddr));
    vrc_host_model host (.clk(clk), .data_out(dout), .data_oe_n(oe_n), .ce_n(ce_n),
        .wr_n(wr_n), .rd_n(rd_n), .data_in(din));
    always #2 clk = ~clk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] cw(int c, int w, logic dir, logic vt, logic slp, logic mcu);
        cw = 32'(c) | (32'(w) << vrc_pkg::CTRL_WCNT_LO) | (32'(w == 3) << vrc_pkg::CTRL_FLEX)
            | (32'(dir) << vrc_pkg::CTRL_DIR) | (32'(vt) << vrc_pkg::CTRL_VTRIG)
            | (32'(slp) << vrc_pkg::CTRL_SLEEP) | (32'(mcu) << vrc_pkg::CTRL_MCU);
    endfunction
    task automatic pulse(input int i);
        @(posedge clk);
        pn[i] <= 1'b0;
        repeat (4) @(posedge clk);
        pn[i] <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic wait_act(input logic v);
        int n;
        n = 0;
        while (act !== v && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        cmp(32'(act), 32'(v), "activity level");
    endtask
    task automatic take(input logic [11:0] s, input int hold);
        exp_q.push_back(s);
        pulse(0);
        wait_act(1'b1);
        repeat (hold) @(posedge clk);
        pulse(1);
        wait_act(1'b0);
    endtask
    task automatic stat;
        apb(1'b0, vrc_pkg::OFS_STATUS, 32'h0);
    endtask
    // Start address checked in the first active cycle
    always @(posedge clk)
    begin
        if (act === 1'b1 && act_d !== 1'b1 && exp_q.size() > 0)
            cmp(32'(maddr), 32'(exp_q.pop_front()), "start address");
        act_d <= act;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_errors++;
            $display("[ERR] %0t run limit reached", $time);
            finish_test();
        end
    end
    initial
    begin
        {clk, arst_n, psel, penable, pwrite, paddr, pwdata, vd, act_d} = '0;
        pn = 3'h7;
        void'($urandom(32'hE73E));
        repeat (12) @(posedge clk);
        cmp(32'(pd), 32'h1, "asleep in reset");
        arst_n <= 1'b1;
        apb(1'b0, vrc_pkg::OFS_CTRL, 32'h0);
        cmp(rv, 32'h0, "control reset value");
        apb(1'b0, 12'h020, 32'h0);
        cmp(32'(er), 32'h1, "unmapped refused");
        $display("test registers done");
        for (int w = 0; w < 3; w++)
        begin
            ch = $urandom_range(7, 0);
            apb(1'b1, vrc_pkg::OFS_CTRL, cw(ch, w, 1'b1, 1'b0, 1'b1, 1'b0));
            repeat (2) take(vrc_pkg::VOICE_BASE + 12'(ch >> w) * (SPAN >> (3 - w)), w == 0 ? 1100 : 8);
        end
        $display("test fixed done");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(0, 3, 1'b1, 1'b0, 1'b1, 1'b0));
        take(vrc_pkg::VOICE_BASE, 8);
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(1, 3, 1'b1, 1'b0, 1'b1, 1'b0));
        take(maddr + 12'h001, 8);
        $display("test flex done");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(ch, 0, 1'b1, 1'b0, 1'b1, 1'b0));
        exp_q.push_back(vrc_pkg::VOICE_BASE + 12'(ch) * (SPAN >> 3));
        pulse(0);
        wait_act(1'b1);
        pulse(2);
        stat();
        cmp(32'(rv[vrc_pkg::ST_WAIT]), 32'h1, "paused flag");
        pulse(0);
        stat();
        cmp(32'(rv[vrc_pkg::ST_WAIT]), 32'h0, "resumed");
        cmp(32'(rv[vrc_pkg::ST_ACTIVE]), 32'h1, "active flag");
        pulse(1);
        wait_act(1'b0);
        $display("test pause done");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(ch, 0, 1'b1, 1'b1, 1'b1, 1'b0));
        pulse(0);
        repeat (20) @(posedge clk);
        cmp(32'(act), 32'h0, "waiting for voice");
        stat();
        cmp(32'(rv[vrc_pkg::ST_WAIT]), 32'h1, "voice wait flag");
        pulse(1);
        stat();
        cmp(32'(rv[vrc_pkg::ST_WAIT]), 32'h0, "wait cancelled");
        exp_q.push_back(vrc_pkg::VOICE_BASE + 12'(ch) * (SPAN >> 3));
        pulse(0);
        vd <= 1'b1;
        wait_act(1'b1);
        pulse(2);
        vd <= 1'b0;
        pulse(0);
        stat();
        cmp(32'(rv[vrc_pkg::ST_WAIT]), 32'h0, "resume skips voice wait");
        pulse(1);
        wait_act(1'b0);
        $display("test voice done");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(ch, 0, 1'b0, 1'b0, 1'b1, 1'b0));
        take(vrc_pkg::VOICE_BASE + 12'(ch) * (SPAN >> 3), 8);
        $display("test playback done");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(ch, 0, 1'b1, 1'b0, 1'b0, 1'b0));
        repeat (20) @(posedge clk);
        cmp(32'(pd), 32'h1, "idle sleeps");
        take(vrc_pkg::VOICE_BASE + 12'(ch) * (SPAN >> 3), 8);
        repeat (20) @(posedge clk);
        cmp(32'(pd), 32'h1, "sleeps after take");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(ch, 0, 1'b1, 1'b0, 1'b1, 1'b0));
        repeat (20) @(posedge clk);
        cmp(32'(pd), 32'h0, "standby awake");
        $display("test sleep done");
        apb(1'b1, vrc_pkg::OFS_CTRL, cw(0, 0, 1'b1, 1'b0, 1'b1, 1'b1));
        host.send(vrc_pkg::CMD_CHAN);
        host.send(4'h8 | 4'(ch));
        host.send(vrc_pkg::CMD_REC);
        exp_q.push_back(vrc_pkg::VOICE_BASE + 12'(ch) * (SPAN >> 3));
        host.send(vrc_pkg::CMD_START);
        wait_act(1'b1);
        host.send(vrc_pkg::CMD_STOP);
        wait_act(1'b0);
        host.rd_stat(hs);
        cmp(32'(hs[vrc_pkg::ST_ACTIVE]), 32'h0, "stopped status");
        cmp(32'(exp_q.size()), 32'h0, "all starts seen");
        $display("test nibble bus done");
        finish_test();
    end
endmodule
